// ===== tb_wbs_ctrl.sv
// Self-checking testbench for the warning controller
`timescale 1ns/100ps
module tb_wbs_ctrl;
  import wbs_pkg::*;
  localparam int unsigned CYC_MAX = 80000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [NUM_IN-1:0] cmd = '0;
  logic [NUM_IN-1:0] pins;
  logic [SPD_W-1:0] speed_x100 = '0;
  logic buzzer;
  logic led_drv_belt;
  logic led_pas_belt;
  logic [SRC_W-1:0] warn_src;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h9a59;

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  wbs_vehicle u_veh (.clk_sys(clk_sys), .cmd(cmd), .pins(pins));

  wbs_ctrl #(.TICK_CYC(1), .DEB_CYC(4)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .ign_on(pins[IN_IGN]), .door_open(pins[IN_DOOR]),
    .key_in(pins[IN_KEY]), .tail_on(pins[IN_TAIL]), .rev_sel(pins[IN_REV]), .stab_active(pins[IN_STAB]),
    .hill_assist(pins[IN_HILL]), .temp_high(pins[IN_TEMP_HI]), .temp_xhigh(pins[IN_TEMP_XH]),
    .drv_unbuckled(pins[IN_DRV_UNB]), .pas_unbuckled(pins[IN_PAS_UNB]), .occupant_on(pins[IN_OCC]),
    .speed_x100(speed_x100), .buzzer(buzzer), .led_drv_belt(led_drv_belt), .led_pas_belt(led_pas_belt),
    .warn_src(warn_src));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic put(input int idx, input logic v);
    cmd[idx] = v;
    cyc(20);
  endtask

  // Looks for a high level on a lamp within n cycles
  task automatic seen_in(ref logic s, input int n, output logic hit);
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      hit = hit | s;
    end
  endtask

  function automatic logic [15:0] exp_src(input logic [NUM_IN-1:0] c, input logic [SPD_W-1:0] s);
    if (c[IN_TEMP_XH]) return 16'(SRC_TEMP_XH);
    if (c[IN_STAB]) return 16'(SRC_STAB);
    if (c[IN_TEMP_HI]) return 16'(SRC_TEMP_HI);
    if (c[IN_IGN] && s >= SPD_OVR_X100) return 16'(SRC_OVSPD);
    if (c[IN_REV]) return 16'(SRC_REV);
    if (!c[IN_IGN] && c[IN_DOOR] && c[IN_KEY]) return 16'(SRC_KEY);
    return 16'(SRC_NONE);
  endfunction

  task automatic tally_and_finish;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == CYC_MAX) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r;
    logic hit;
    int n;
    cyc(8);
    resetn = 1'b1;
    cyc(3);
    check(16'({buzzer, led_drv_belt, led_pas_belt, warn_src}), 16'h0000);
    // Short pulse must be filtered out
    cmd[IN_REV] = 1'b1;
    cyc(2);
    put(IN_REV, 1'b0);
    check(16'(warn_src), 16'(SRC_NONE));
    $display("test reset_glitch done");

    // ****************************************
    // Overspeed boundary, then random mix
    // ****************************************
    cmd[IN_IGN] = 1'b1;
    speed_x100 = 16'(SPD_OVR_X100 - 1);
    cyc(20);
    check(16'(warn_src), 16'(SRC_NONE));
    speed_x100 = 16'(SPD_OVR_X100);
    cyc(5);
    check(16'(warn_src), 16'(SRC_OVSPD));
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      cmd = '0;
      cmd[IN_IGN] = r[0];
      cmd[IN_REV] = r[1] & r[8];
      cmd[IN_STAB] = r[2] & r[9];
      cmd[IN_TEMP_HI] = r[3] & r[10];
      cmd[IN_TEMP_XH] = r[4] & r[11] & r[12];
      cmd[IN_DOOR] = r[5];
      cmd[IN_KEY] = r[6];
      speed_x100 = r[31:16];
      cyc(20);
      check(16'(warn_src), exp_src(cmd, speed_x100));
    end
    cmd = '0;
    speed_x100 = '0;
    cyc(20);
    $display("test random_sources done");

    // ****************************************
    // Lamp delay and hill assist beeps
    // ****************************************
    put(IN_TAIL, 1'b1);
    cmd[IN_DOOR] = 1'b1;
    cyc(100);
    check(16'(warn_src), 16'(SRC_NONE));
    cyc(200);
    check(16'(warn_src), 16'(SRC_LAMP));
    put(IN_DOOR, 1'b0);
    put(IN_TAIL, 1'b0);
    check(16'(warn_src), 16'(SRC_NONE));
    put(IN_HILL, 1'b1);
    check(16'(warn_src), 16'(SRC_HILL));
    cyc(400);
    check(16'(warn_src), 16'(SRC_NONE));
    put(IN_HILL, 1'b0);
    cyc(200);
    check(16'(warn_src), 16'(SRC_HILL));
    cyc(300);
    check(16'(warn_src), 16'(SRC_NONE));
    $display("test lamp_hill done");

    // ****************************************
    // Seatbelt sequences for both seats
    // ****************************************
    cmd[IN_IGN] = 1'b1;
    cmd[IN_DRV_UNB] = 1'b1;
    speed_x100 = 16'(SPD_BELT_X100 - 1);
    cyc(20);
    check(16'(warn_src), 16'(SRC_NONE));
    speed_x100 = 16'(SPD_BELT_X100);
    cyc(5);
    check(16'(warn_src), 16'(SRC_BELT));
    speed_x100 = '0;
    cyc(50);
    check(16'(warn_src), 16'(SRC_BELT));
    put(IN_DRV_UNB, 1'b0);
    check(16'(warn_src), 16'(SRC_NONE));
    put(IN_DRV_UNB, 1'b1);
    speed_x100 = 16'(SPD_BELT_X100);
    cyc(5);
    put(IN_IGN, 1'b0);
    check(16'(warn_src), 16'(SRC_NONE));
    cmd[IN_DRV_UNB] = 1'b0;
    cmd[IN_IGN] = 1'b1;
    cmd[IN_OCC] = 1'b1;
    put(IN_PAS_UNB, 1'b1);
    check(16'(warn_src), 16'(SRC_BELT));
    put(IN_OCC, 1'b0);
    check(16'(warn_src), 16'(SRC_NONE));
    speed_x100 = '0;
    $display("test belt_sequence done");

    // ****************************************
    // Belt lamps
    // ****************************************
    cmd = '0;
    put(IN_DRV_UNB, 1'b1);
    seen_in(led_drv_belt, 1100, hit);
    check(16'(hit), 16'h0001);
    put(IN_DRV_UNB, 1'b0);
    seen_in(led_drv_belt, 1100, hit);
    check(16'(hit), 16'h0000);
    cmd[IN_IGN] = 1'b1;
    cmd[IN_OCC] = 1'b1;
    put(IN_PAS_UNB, 1'b1);
    seen_in(led_pas_belt, 1100, hit);
    check(16'(hit), 16'h0001);
    put(IN_PAS_UNB, 1'b0);
    seen_in(led_pas_belt, 1100, hit);
    check(16'(hit), 16'h0000);
    put(IN_PAS_UNB, 1'b1);
    put(IN_OCC, 1'b0);
    seen_in(led_pas_belt, 1100, hit);
    check(16'(hit), 16'h0000);
    cmd = '0;
    $display("test belt_lamps done");

    // ****************************************
    // Tone half period on a continuous source
    // ****************************************
    put(IN_STAB, 1'b1);
    n = 0;
    while (buzzer !== 1'b1 && n < 30000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (buzzer === 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'(TONE_HALF_CYC));
    $display("test tone done");
    tally_and_finish();
  end
endmodule

// ===== wbs_ctrl.sv
// Warning buzzer and seatbelt warning lamp controller, top level
//
// Behaviour
// - Key warning sounds with ignition off, door open and key inserted.
// - Lamp warning: ignition off, tails on, door open at least 0.22 s.
// - Reverse warning sounds while reverse is selected and no higher-priority warning is active.
// - Buzzer tone is approximately 1.95 kHz.
// - Sideslip warning sounds while stability control is active.
// - One beep when hill assist starts, two when it completes.
// - Actuator temperature high beeps intermittently, extremely high sounds continuously.
// - Overspeed warning with ignition on and speed at least 117.14 km/h.
// - Driver unbuckled, ignition on, 20 km/h reached: level 1, 1.2 s beeps.
// - After 30 s level 2: 0.4 s beeps for 90 s, then stop.
// - Buckling or ignition off cancels level 1 or level 2 at once.
// - Speed falling below 20 km/h does not cancel the warning.
// - A finished sequence does not restart on speed dipping and recovering.
// - Passenger runs same sequence with occupant on and buckle unfastened.
// - Driver LED blinks while unbuckled, off when buckled.
// - Passenger LED blinks with ignition on, occupant on, buckle unfastened.
// - Passenger LED off once occupant leaves or buckle fastens.
`timescale 1ns/100ps

module wbs_ctrl
  import wbs_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF,
  parameter int unsigned DEB_CYC = DEB_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Vehicle switches and sensors, asynchronous
  input wire logic ign_on,
  input wire logic door_open,
  input wire logic key_in,
  input wire logic tail_on,
  input wire logic rev_sel,
  input wire logic stab_active,
  input wire logic hill_assist,
  input wire logic temp_high,
  input wire logic temp_xhigh,
  input wire logic drv_unbuckled,
  input wire logic pas_unbuckled,
  input wire logic occupant_on,
  // Vehicle speed from cluster logic, same clock
  input wire logic [SPD_W-1:0] speed_x100,
  // Buzzer and lamps
  output logic buzzer,
  output logic led_drv_belt,
  output logic led_pas_belt,
  // Status
  output logic [SRC_W-1:0] warn_src
);

  // At least one bit, so a tick on every cycle still elaborates
  localparam int unsigned TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'h0;
      rst_n_r <= 1'h0;
    end else begin
      rst_s1_r <= 1'h1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [NUM_IN-1:0] pin_vec;
  logic [NUM_IN-1:0] deb;

  assign pin_vec[IN_IGN] = ign_on;
  assign pin_vec[IN_DOOR] = door_open;
  assign pin_vec[IN_KEY] = key_in;
  assign pin_vec[IN_TAIL] = tail_on;
  assign pin_vec[IN_REV] = rev_sel;
  assign pin_vec[IN_STAB] = stab_active;
  assign pin_vec[IN_HILL] = hill_assist;
  assign pin_vec[IN_TEMP_HI] = temp_high;
  assign pin_vec[IN_TEMP_XH] = temp_xhigh;
  assign pin_vec[IN_DRV_UNB] = drv_unbuckled;
  assign pin_vec[IN_PAS_UNB] = pas_unbuckled;
  assign pin_vec[IN_OCC] = occupant_on;

  for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_deb
    wbs_debounce #(
      .DEB_CYC(DEB_CYC)
    ) u_deb (
      .clk_sys(clk_sys),
      .rst_n(rst_n_r),
      .pin(pin_vec[gi]),
      .level(deb[gi])
    );
  end

  logic ign;
  logic door;
  logic occ;
  logic spd_belt;
  logic spd_ovr;

  assign ign = deb[IN_IGN];
  assign door = deb[IN_DOOR];
  assign occ = deb[IN_OCC];
  assign spd_belt = speed_x100 >= SPD_W'(SPD_BELT_X100);
  assign spd_ovr = speed_x100 >= SPD_W'(SPD_OVR_X100);

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= '0;
      tick_r <= 1'h0;
    end else if (tick_cnt_r == TW'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'h1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'h1;
      tick_r <= 1'h0;
    end
  end

  // ****************************************
  // Tone generator
  // ****************************************
  logic [TONE_W-1:0] tone_cnt_r;
  logic tone_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tone_cnt_r <= '0;
      tone_r <= 1'h0;
    end else if (tone_cnt_r == TONE_W'(TONE_HALF_CYC - 1)) begin
      tone_cnt_r <= '0;
      tone_r <= ~tone_r;
    end else begin
      tone_cnt_r <= tone_cnt_r + 1'h1;
    end
  end

  // ****************************************
  // Free cadences for beeps and lamps
  // ****************************************
  logic [MS_W-1:0] temp_ph_r;
  logic [MS_W-1:0] rev_ph_r;
  logic [MS_W-1:0] led_ph_r;
  logic blink_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      temp_ph_r <= '0;
      rev_ph_r <= '0;
      led_ph_r <= '0;
      blink_r <= 1'h0;
    end else if (tick_r) begin
      temp_ph_r <= (temp_ph_r == MS_W'(TEMP_PER_MS - 1)) ? '0 : temp_ph_r + 1'h1;
      rev_ph_r <= (rev_ph_r == MS_W'(REV_PER_MS - 1)) ? '0 : rev_ph_r + 1'h1;
      if (led_ph_r == MS_W'(LED_HALF_MS - 1)) begin
        led_ph_r <= '0;
        blink_r <= ~blink_r;
      end else begin
        led_ph_r <= led_ph_r + 1'h1;
      end
    end
  end

  // ****************************************
  // Door-open age for lamp warning
  // ****************************************
  logic [MS_W-1:0] door_ms_r;
  logic door_aged_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      door_ms_r <= '0;
      door_aged_r <= 1'h0;
    end else if (!door) begin
      door_ms_r <= '0;
      door_aged_r <= 1'h0;
    end else if (tick_r && !door_aged_r) begin
      door_ms_r <= door_ms_r + 1'h1;
      if (door_ms_r == MS_W'(LAMP_DLY_MS - 1)) begin
        door_aged_r <= 1'h1;
      end
    end
  end

  // ****************************************
  // Hill-start assist beeps
  // ****************************************
  logic hill_prev_r;
  logic [HILL_W-1:0] hill_left_r;
  logic [MS_W-1:0] hill_ph_r;
  logic hill_beep;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hill_prev_r <= 1'h0;
      hill_left_r <= '0;
      hill_ph_r <= '0;
    end else begin
      hill_prev_r <= deb[IN_HILL];
      if (deb[IN_HILL] && !hill_prev_r) begin
        hill_left_r <= HILL_START_BEEPS;
        hill_ph_r <= '0;
      end else if (!deb[IN_HILL] && hill_prev_r) begin
        hill_left_r <= HILL_DONE_BEEPS;
        hill_ph_r <= '0;
      end else if (tick_r && (hill_left_r != '0)) begin
        if (hill_ph_r == MS_W'(HILL_PER_MS - 1)) begin
          hill_ph_r <= '0;
          hill_left_r <= hill_left_r - 1'h1;
        end else begin
          hill_ph_r <= hill_ph_r + 1'h1;
        end
      end
    end
  end

  assign hill_beep = (hill_left_r != '0) && (hill_ph_r < MS_W'(BEEP_ON_MS));

  // ****************************************
  // Seatbelt two-level sequences
  // ****************************************
  logic [NUM_SEAT-1:0] belt_arm;
  wbs_belt_t belt_st_r [NUM_SEAT];
  logic [MS_W-1:0] belt_dur_r [NUM_SEAT];
  logic [MS_W-1:0] belt_ph_r [NUM_SEAT];
  logic belt_act;
  logic belt_beep;

  assign belt_arm[SEAT_DRV] = ign && deb[IN_DRV_UNB];
  assign belt_arm[SEAT_PAS] = ign && occ && deb[IN_PAS_UNB];

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int s = 0; s < NUM_SEAT; s++) begin
        belt_st_r[s] <= BELT_IDLE;
        belt_dur_r[s] <= '0;
        belt_ph_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NUM_SEAT; s++) begin
        case (belt_st_r[s])
          BELT_IDLE: begin
            if (belt_arm[s] && spd_belt) begin
              belt_st_r[s] <= BELT_L1;
              belt_dur_r[s] <= '0;
              belt_ph_r[s] <= '0;
            end
          end
          BELT_L1: begin
            if (!belt_arm[s]) begin
              belt_st_r[s] <= BELT_IDLE;
            end else if (tick_r) begin
              if (belt_dur_r[s] == MS_W'(L1_DUR_MS - 1)) begin
                belt_st_r[s] <= BELT_L2;
                belt_dur_r[s] <= '0;
                belt_ph_r[s] <= '0;
              end else begin
                belt_dur_r[s] <= belt_dur_r[s] + 1'h1;
                belt_ph_r[s] <= (belt_ph_r[s] == MS_W'(L1_PER_MS - 1)) ? '0 : belt_ph_r[s] + 1'h1;
              end
            end
          end
          BELT_L2: begin
            if (!belt_arm[s]) begin
              belt_st_r[s] <= BELT_IDLE;
            end else if (tick_r) begin
              if (belt_dur_r[s] == MS_W'(L2_DUR_MS - 1)) begin
                belt_st_r[s] <= BELT_DONE;
              end else begin
                belt_dur_r[s] <= belt_dur_r[s] + 1'h1;
                belt_ph_r[s] <= (belt_ph_r[s] == MS_W'(L2_PER_MS - 1)) ? '0 : belt_ph_r[s] + 1'h1;
              end
            end
          end
          default: begin
            // only re-arm via buckle, ignition off or, for the passenger, occupant off
            if (!belt_arm[s]) begin
              belt_st_r[s] <= BELT_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    belt_act = 1'h0;
    belt_beep = 1'h0;
    for (int s = 0; s < NUM_SEAT; s++) begin
      if ((belt_st_r[s] == BELT_L1) || (belt_st_r[s] == BELT_L2)) begin
        belt_act = 1'h1;
        if (belt_ph_r[s] < MS_W'(BEEP_ON_MS)) begin
          belt_beep = 1'h1;
        end
      end
    end
  end

  // ****************************************
  // Warning conditions
  // ****************************************
  logic key_w;
  logic lamp_w;
  logic ovspd_w;
  logic temp_beep;
  logic rev_beep;

  assign key_w = !ign && door && deb[IN_KEY];
  assign lamp_w = !ign && deb[IN_TAIL] && door_aged_r;
  assign ovspd_w = ign && spd_ovr;
  assign temp_beep = temp_ph_r < MS_W'(TEMP_ON_MS);
  assign rev_beep = rev_ph_r < MS_W'(REV_ON_MS);

  // ****************************************
  // Priority select
  // ****************************************
  wbs_src_t src_nxt;
  logic gate_nxt;

  always_comb begin
    src_nxt = SRC_NONE;
    gate_nxt = 1'h0;
    if (deb[IN_TEMP_XH]) begin
      src_nxt = SRC_TEMP_XH;
      gate_nxt = 1'h1;
    end else if (deb[IN_STAB]) begin
      src_nxt = SRC_STAB;
      gate_nxt = 1'h1;
    end else if (hill_left_r != '0) begin
      src_nxt = SRC_HILL;
      gate_nxt = hill_beep;
    end else if (deb[IN_TEMP_HI]) begin
      src_nxt = SRC_TEMP_HI;
      gate_nxt = temp_beep;
    end else if (ovspd_w) begin
      src_nxt = SRC_OVSPD;
      gate_nxt = 1'h1;
    end else if (belt_act) begin
      src_nxt = SRC_BELT;
      gate_nxt = belt_beep;
    end else if (deb[IN_REV]) begin
      src_nxt = SRC_REV;
      gate_nxt = rev_beep;
    end else if (key_w) begin
      src_nxt = SRC_KEY;
      gate_nxt = 1'h1;
    end else if (lamp_w) begin
      src_nxt = SRC_LAMP;
      gate_nxt = 1'h1;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      buzzer <= 1'h0;
      warn_src <= '0;
    end else begin
      buzzer <= gate_nxt && tone_r;
      warn_src <= src_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      led_drv_belt <= 1'h0;
      led_pas_belt <= 1'h0;
    end else begin
      led_drv_belt <= deb[IN_DRV_UNB] && blink_r;
      led_pas_belt <= ign && occ && deb[IN_PAS_UNB] && blink_r;
    end
  end

endmodule

// ===== wbs_ctrl_assertions.sv
// Port-level checker for the warning controller
`timescale 1ns/100ps
module wbs_ctrl_checker
  import wbs_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Watched ports
  input wire logic [SPD_W-1:0] speed_x100,
  input wire logic buzzer,
  input wire logic led_drv_belt,
  input wire logic led_pas_belt,
  input wire logic [SRC_W-1:0] warn_src
);
  // ****************************************
  // Run-length helpers
  // ****************************************
  int unsigned buz_run_r;
  int unsigned ldrv_run_r;
  int unsigned lpas_run_r;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      buz_run_r <= 0;
      ldrv_run_r <= 0;
      lpas_run_r <= 0;
    end else begin
      buz_run_r <= buzzer ? buz_run_r + 1 : 0;
      ldrv_run_r <= led_drv_belt ? ldrv_run_r + 1 : 0;
      lpas_run_r <= led_pas_belt ? lpas_run_r + 1 : 0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ****************************************
  // Assertions
  // ****************************************
  AST_SRC_RANGE: assert property (warn_src <= SRC_LAMP)
    else $error("warn_src outside the source list");
  AST_BUZ_QUIET: assert property ((warn_src == SRC_NONE) [*3] |-> !buzzer)
    else $error("buzzer sounds with no source selected");
  AST_TONE_HALF: assert property (buzzer |-> buz_run_r < TONE_HALF_CYC)
    else $error("buzzer high longer than a tone half period");
  AST_LED_DRV_RUN: assert property (led_drv_belt |-> ldrv_run_r < LED_HALF_MS * TICK_CYC)
    else $error("driver belt lamp lit longer than a blink phase");
  AST_LED_PAS_RUN: assert property (led_pas_belt |-> lpas_run_r < LED_HALF_MS * TICK_CYC)
    else $error("passenger belt lamp lit longer than a blink phase");
  AST_RESET_QUIET: assert property ($rose(resetn) |->
    (!buzzer && !led_drv_belt && !led_pas_belt && warn_src == SRC_NONE) [*2])
    else $error("outputs active right after reset release");
  AST_OVSPD_SRC: assert property ($rose(warn_src == SRC_OVSPD) |-> $past(speed_x100, 1) >= SPD_OVR_X100
    || $past(speed_x100, 2) >= SPD_OVR_X100 || $past(speed_x100, 3) >= SPD_OVR_X100)
    else $error("overspeed selected without speed at threshold");
  AST_OVSPD_DROP: assert property ((speed_x100 < SPD_OVR_X100) [*4] |-> warn_src != SRC_OVSPD)
    else $error("overspeed held after speed fell below threshold");
endmodule

bind wbs_ctrl wbs_ctrl_checker #(.TICK_CYC(TICK_CYC)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
  .speed_x100(speed_x100), .buzzer(buzzer), .led_drv_belt(led_drv_belt), .led_pas_belt(led_pas_belt),
  .warn_src(warn_src));

// ===== wbs_debounce.sv
// Package of constants and the input synchroniser/debouncer for the warning controller
package wbs_pkg;

  // ****************************************
  // Clock and tick
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DEB_MS = 10;
  localparam int unsigned DEB_CYC_DEF = DEB_MS * TICK_CYC_DEF;

  // ****************************************
  // Buzzer tone, approx 1.95 kHz
  // ****************************************
  localparam int unsigned TONE_HZ = 1950;
  localparam int unsigned TONE_HALF_CYC = (CLK_HZ + TONE_HZ) / (2 * TONE_HZ);
  localparam int unsigned TONE_W = $clog2(TONE_HALF_CYC);

  // ****************************************
  // Times in ms (one tick each)
  // ****************************************
  localparam int unsigned MS_W = 17;
  localparam int unsigned LAMP_DLY_MS = 220;
  localparam int unsigned L1_PER_MS = 1200;
  localparam int unsigned L2_PER_MS = 400;
  localparam int unsigned L1_DUR_MS = 30000;
  localparam int unsigned L2_DUR_MS = 90000;
  localparam int unsigned BEEP_ON_MS = 100;
  localparam int unsigned HILL_PER_MS = 200;
  localparam int unsigned TEMP_PER_MS = 500;
  localparam int unsigned TEMP_ON_MS = 250;
  localparam int unsigned REV_PER_MS = 1000;
  localparam int unsigned REV_ON_MS = 500;
  localparam int unsigned LED_HALF_MS = 500;

  // ****************************************
  // Speed thresholds, units of 0.01 km/h
  // ****************************************
  localparam int unsigned SPD_W = 16;
  localparam int unsigned SPD_OVR_X100 = 11714;
  localparam int unsigned SPD_BELT_X100 = 2000;

  // ****************************************
  // Input vector layout
  // ****************************************
  localparam int unsigned IN_IGN = 0;
  localparam int unsigned IN_DOOR = 1;
  localparam int unsigned IN_KEY = 2;
  localparam int unsigned IN_TAIL = 3;
  localparam int unsigned IN_REV = 4;
  localparam int unsigned IN_STAB = 5;
  localparam int unsigned IN_HILL = 6;
  localparam int unsigned IN_TEMP_HI = 7;
  localparam int unsigned IN_TEMP_XH = 8;
  localparam int unsigned IN_DRV_UNB = 9;
  localparam int unsigned IN_PAS_UNB = 10;
  localparam int unsigned IN_OCC = 11;
  localparam int unsigned NUM_IN = 12;

  localparam int unsigned NUM_SEAT = 2;
  localparam int unsigned SEAT_DRV = 0;
  localparam int unsigned SEAT_PAS = 1;
  localparam int unsigned HILL_W = 2;
  localparam logic [HILL_W-1:0] HILL_START_BEEPS = 2'h1;
  localparam logic [HILL_W-1:0] HILL_DONE_BEEPS = 2'h2;
  localparam int unsigned SRC_W = 4;

  typedef enum logic [1:0] {BELT_IDLE, BELT_L1, BELT_L2, BELT_DONE} wbs_belt_t;

  typedef enum logic [SRC_W-1:0] {
    SRC_NONE, SRC_TEMP_XH, SRC_STAB, SRC_HILL, SRC_TEMP_HI,
    SRC_OVSPD, SRC_BELT, SRC_REV, SRC_KEY, SRC_LAMP
  } wbs_src_t;

endpackage

`timescale 1ns/100ps

module wbs_debounce #(
  parameter int unsigned DEB_CYC = 500000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw pin and clean level
  input wire logic pin,
  output logic level
);

  localparam int unsigned CW = $clog2(DEB_CYC + 1);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic [CW-1:0] cnt_r;

  // ****************************************
  // Three-stage synchroniser
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ****************************************
  // Debounce: new value must hold steady
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      level <= 1'h0;
    end else if ((s2_r != s3_r) || (s3_r == level)) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(DEB_CYC - 1)) begin
      cnt_r <= '0;
      level <= s3_r;
    end else begin
      cnt_r <= cnt_r + 1'h1;
    end
  end

endmodule

// ===== wbs_vehicle.sv
// Vehicle switch harness model with contact bounce
`timescale 1ns/100ps
module wbs_vehicle
  import wbs_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Commanded switch levels
  input wire logic [NUM_IN-1:0] cmd,
  // Switch pins towards the cluster
  output logic [NUM_IN-1:0] pins
);
  logic [NUM_IN-1:0] last_r = '0;
  logic [NUM_IN-1:0] chg_r = '0;
  logic [1:0] bnc_r = 2'h0;

  always_ff @(posedge clk_sys) begin
    last_r <= cmd;
    if (cmd != last_r) begin
      chg_r <= cmd ^ last_r;
      bnc_r <= 2'h3;
    end else if (bnc_r != 2'h0) begin
      bnc_r <= bnc_r - 2'h1;
    end
  end

  // Odd bounce steps show the old contact level
  assign pins = cmd ^ (chg_r & {NUM_IN{bnc_r[0]}});
endmodule
